//--- verilog/hepp_defs.vh
// constants for the header encoded packet port
`ifndef HEPP_DEFS_VH
`define HEPP_DEFS_VH
`define HEPP_TAG_HI 63
`define HEPP_TAG_LO 56
`define HEPP_FT_HI 55
`define HEPP_FT_LO 52
`define HEPP_TT_HI 51
`define HEPP_TT_LO 48
`define HEPP_PRIO_HI 46
`define HEPP_PRIO_LO 45
`define HEPP_CRF_BIT 44
`define HEPP_SIZE_HI 43
`define HEPP_SIZE_LO 36
`define HEPP_ERR_BIT 35
`define HEPP_ADDR_HI 33
`define HEPP_ADDR_LO 0
`define HEPP_INFO_HI 31
`define HEPP_INFO_LO 16
`define HEPP_MLEN_HI 63
`define HEPP_MLEN_LO 60
`define HEPP_MSEG_HI 59
`define HEPP_MSEG_LO 56
`define HEPP_MBOX_HI 9
`define HEPP_MBOX_LO 4
`define HEPP_LET_HI 1
`define HEPP_LET_LO 0
`define HEPP_FT_NREAD 4'h2
`define HEPP_FT_WRITE 4'h5
`define HEPP_FT_SWRITE 4'h6
`define HEPP_FT_MAINT 4'h8
`define HEPP_FT_DBELL 4'hA
`define HEPP_FT_MSG 4'hB
`define HEPP_FT_RESP 4'hD
`define HEPP_FT_FOUR 4'h4
`define HEPP_TT_MRD_REQ 4'h0
`define HEPP_TT_MWR_REQ 4'h1
`define HEPP_TT_MRD_RSP 4'h2
`define HEPP_TT_MWR_RSP 4'h3
`define HEPP_ST_DONE 4'h0
`define HEPP_RSVD_RD 1'b0
`define HEPP_RSVD_WR 1'b1
`define HEPP_ADDR_ERR 8'h01
`define HEPP_ADDR_STAT 8'h00
`define HEPP_ADDR_CTRL 8'h04
`define HEPP_ADDR_ENC 8'h08
`define HEPP_ADDR_DEC 8'h0C
`define HEPP_ADDR_DFIELD 8'h10
`define HEPP_CTRL_RST 32'h0000_007F
`endif

//--- verilog/hepp_hdr_decode.v
// header field checks on the first beat of a packet
`timescale 1ns/100ps
module hepp_hdr_decode (
  // header in
  input wire [63:0] header,
  input wire [5:0] formatEnable,
  // checks out
  output wire formatOk,
  output wire subtypeUsed,
  output wire maintOk,
  output wire [3:0] formatType
);
  `include "hepp_defs.vh"
  wire [3:0] tt;
  assign formatType = header[`HEPP_FT_HI:`HEPP_FT_LO];
  assign tt = header[`HEPP_TT_HI:`HEPP_TT_LO];
  assign formatOk =
    (formatType == `HEPP_FT_NREAD && formatEnable[0]) ||
    (formatType == `HEPP_FT_WRITE && formatEnable[1]) ||
    (formatType == `HEPP_FT_SWRITE && formatEnable[2]) ||
    (formatType == `HEPP_FT_DBELL && formatEnable[3]) ||
    (formatType == `HEPP_FT_MSG && formatEnable[4]) ||
    (formatType == `HEPP_FT_RESP && formatEnable[5]);
  assign subtypeUsed = (formatType == `HEPP_FT_NREAD) ||
    (formatType == `HEPP_FT_FOUR) || (formatType == `HEPP_FT_RESP);
  assign maintOk = (formatType == `HEPP_FT_MAINT) &&
    (tt <= `HEPP_TT_MWR_RSP);
endmodule // hepp_hdr_decode

//--- verilog/hepp_beat_stage.v
// one-entry register slice for a stream channel
`timescale 1ns/100ps
module hepp_beat_stage #(
  parameter DW = 64
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // upstream
  input wire sValid,
  output wire sReady,
  input wire [DW-1:0] sData,
  input wire [DW/8-1:0] sKeep,
  input wire sLast,
  input wire [31:0] sUser,
  // downstream
  output reg mValid,
  input wire mReady,
  output reg [DW-1:0] mData,
  output reg [DW/8-1:0] mKeep,
  output reg mLast,
  output reg [31:0] mUser
);
  assign sReady = !mValid || mReady;
  always @(posedge ref_clk) begin
    if (rst) begin
      mValid <= 1'b0;
      mData <= {DW{1'b0}};
      mKeep <= {(DW/8){1'b0}};
      mLast <= 1'b0;
      mUser <= 32'h0000_0000;
    end else if (sReady) begin
      mValid <= sValid;
      if (sValid) begin
        mData <= sData;
        mKeep <= sKeep;
        mLast <= sLast;
        mUser <= sUser;
      end
    end
  end
endmodule // hepp_beat_stage

//--- verilog/hepp_packet_port.v
// header encoded packet port: request path and response path
// Summary of operation
// - maintenance uses format 8, subtypes 0-3 for read/write request/response
// - a beat moves only when valid and ready are both high
// - last marks final beat of each packet
// - keep vector marks valid bytes of each beat
// - header alone on first beat, payload on later aligned beats
// - bits 55:52 format; only 2,5,6,A,B,D and maintenance 8, maybe a configured subset
// - bits 51:48 subtype, meaningful only for formats 2, 4, 13; maintOk also decodes it for maintenance format 8
// - bit 44 is the critical flow flag
// - bits 43:36 size minus one, 0-255 meaning 1-256 bytes
// - bit 35 error flag, only meaningful in responses
// - bits 33:0 byte address for addressed types
// - bits 31:16 doorbell information field
// - message count-1 in 63:60, segment-1 in 59:56
// - message mailbox in bits 9:4, upper bits reserved if multi-segment
// - message letter in bits 1:0
// - received response status reduced to error bit, clear only if done
`timescale 1ns/100ps
module hepp_packet_port #(
  parameter DW = 64
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // user request stream in
  input wire reqValid,
  output wire reqReady,
  input wire [DW-1:0] reqData,
  input wire [DW/8-1:0] reqKeep,
  input wire reqLast,
  input wire [31:0] reqUser,
  // request stream to link side
  output wire txValid,
  input wire txReady,
  output wire [DW-1:0] txData,
  output wire [DW/8-1:0] txKeep,
  output wire txLast,
  output wire [31:0] txUser,
  // received response from link side, raw status
  input wire rxValid,
  output reg rxReady,
  input wire [DW-1:0] rxData,
  input wire [DW/8-1:0] rxKeep,
  input wire rxLast,
  input wire [31:0] rxUser,
  input wire [3:0] rxStatus,
  // response stream to user
  output reg rspValid,
  input wire rspReady,
  output reg [DW-1:0] rspData,
  output reg [DW/8-1:0] rspKeep,
  output reg rspLast,
  output reg [31:0] rspUser
);
  `include "hepp_defs.vh"
  reg [31:0] ctrl;
  reg [7:0] errCount;
  reg [7:0] maintCount;
  reg reqInBody;
  reg rxInBody;
  reg [3:0] lastFormat;
  wire formatOk;
  wire subtypeUsed;
  wire maintOk;
  wire [3:0] reqFormat;
  wire stageReady;
  wire reqBeat;
  wire reqHdr;
  wire hdrBad;
  wire rxBeat;
  wire rspFree;
  wire next_rspValid;
  reg [DW-1:0] rxHdrBeat;
  wire apbAccess;

  hepp_hdr_decode u_dec (
    .header(reqData[63:0]),
    .formatEnable(ctrl[5:0]),
    .formatOk(formatOk),
    .subtypeUsed(subtypeUsed),
    .maintOk(maintOk),
    .formatType(reqFormat)
  );

  assign reqReady = stageReady;
  assign reqBeat = reqValid && stageReady;
  assign reqHdr = reqBeat && !reqInBody;
  // headers of a disabled or unknown format are counted, passed untouched
  assign hdrBad = reqHdr && !formatOk && !(ctrl[6] && maintOk);

  hepp_beat_stage #(.DW(DW)) u_stage (
    .ref_clk(ref_clk),
    .rst(rst),
    .sValid(reqValid),
    .sReady(stageReady),
    .sData(reqData),
    .sKeep(reqKeep),
    .sLast(reqLast),
    .sUser(reqUser),
    .mValid(txValid),
    .mReady(txReady),
    .mData(txData),
    .mKeep(txKeep),
    .mLast(txLast),
    .mUser(txUser)
  );

  // packet boundary tracking from last alone
  always @(posedge ref_clk) begin
    if (rst) begin
      reqInBody <= 1'b0;
      lastFormat <= 4'h0;
    end else if (reqBeat) begin
      reqInBody <= !reqLast;
      // header beat is first beat only
      if (reqHdr) begin
        lastFormat <= reqFormat;
      end
    end
  end

  always @* begin
    rxHdrBeat = rxData;
    rxHdrBeat[`HEPP_ERR_BIT] = rxStatus != `HEPP_ST_DONE;
  end
  assign rspFree = !rspValid || rspReady;
  assign rxBeat = rxValid && rxReady;
  assign next_rspValid = rxBeat || !rspFree;

  always @(posedge ref_clk) begin
    if (rst) begin
      rxReady <= 1'b0;
    end else begin
      // registered ready: only offered when the slot is empty next cycle,
      // which halves throughput but never overwrites a held beat
      rxReady <= !next_rspValid;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rspValid <= 1'b0;
      rspData <= {DW{1'b0}};
      rspKeep <= {(DW/8){1'b0}};
      rspLast <= 1'b0;
      rspUser <= 32'h0000_0000;
      rxInBody <= 1'b0;
    end else begin
      if (rspValid && rspReady) begin
        rspValid <= 1'b0;
      end
      // response beat taken when both high
      if (rxBeat) begin
        rspValid <= 1'b1;
        // error only written on header of response
        rspData <= rxInBody ? rxData : rxHdrBeat;
        rspKeep <= rxKeep;
        rspLast <= rxLast;
        rspUser <= rxUser;
        rxInBody <= !rxLast;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      errCount <= 8'h00;
      maintCount <= 8'h00;
    end else begin
      if (hdrBad && errCount != 8'hFF) begin
        errCount <= errCount + 8'h01;
      end
      if (reqHdr && maintOk && maintCount != 8'hFF) begin
        maintCount <= maintCount + 8'h01;
      end
    end
  end

  // apb: one wait state, pready registered high the cycle after the access cycle starts
  assign apbAccess = psel && penable && !pready;
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= `HEPP_CTRL_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apbAccess;
      pslverr <= 1'b0;
      if (apbAccess) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `HEPP_ADDR_STAT: begin
            prdata <= {16'h0000, maintCount, errCount};
          end
          `HEPP_ADDR_CTRL: begin
            if (pwrite) begin
              ctrl <= {25'h0, pwdata[6:0]};
            end
            prdata <= ctrl;
          end
          `HEPP_ADDR_ENC: begin
            prdata <= {24'h0, reqInBody, rxInBody, 2'b00, lastFormat};
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // hepp_packet_port

//--- dv/hepp_packet_port_chk.sv
// port assertions for the header encoded packet port
`timescale 1ns/100ps
module hepp_packet_port_chk #(
  parameter DW = 64
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // request path
  input wire reqValid,
  input wire reqReady,
  input wire [DW-1:0] reqData,
  input wire reqLast,
  input wire txValid,
  input wire txReady,
  input wire [DW-1:0] txData,
  input wire txLast,
  // response path
  input wire rxValid,
  input wire rxReady,
  input wire rxLast,
  input wire [3:0] rxStatus,
  input wire rspValid,
  input wire rspReady,
  input wire [DW-1:0] rspData,
  input wire rspLast
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // header beat tracker: only the first beat carries status
  reg rxFirst;
  always @(posedge ref_clk)
    if (rst) rxFirst <= 1'b1;
    else if (rxValid && rxReady) rxFirst <= rxLast;
  property p_apb_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb no answer");
  property p_apb_pulse;
    pready |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready held");
  property p_slverr;
    pslverr |-> pready;
  endproperty
  a_slverr: assert property (p_slverr) else $error("lone slverr");
  property p_tx_hold;
    txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx beat moved");
  property p_rsp_hold;
    rspValid && !rspReady |=> rspValid && $stable(rspData);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("rsp moved");
  property p_tx_fwd;
    reqValid && reqReady |=> txValid && txData == $past(reqData)
      && txLast == $past(reqLast);
  endproperty
  a_tx_fwd: assert property (p_tx_fwd) else $error("req lost");
  property p_err_bit;
    rxValid && rxReady && rxFirst |=> rspValid
      && rspData[35] == ($past(rxStatus) != 4'h0);
  endproperty
  a_err_bit: assert property (p_err_bit) else $error("bad err bit");
  property p_rsp_last;
    rxValid && rxReady |=> rspValid && rspLast == $past(rxLast);
  endproperty
  a_rsp_last: assert property (p_rsp_last) else $error("last lost");
  property p_rst_idle;
    $fell(rst) |-> !txValid && !rspValid && !pready;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("busy at reset");
  c_tx_last: cover property (txValid && txReady && txLast);
  c_slverr: cover property (pslverr);
  c_rsp_stall: cover property (rspValid && !rspReady);
endmodule // hepp_packet_port_chk
bind hepp_packet_port hepp_packet_port_chk #(.DW(DW)) u_chk (.ref_clk,
  .rst, .psel, .penable, .pready, .pslverr, .reqValid, .reqReady, .reqData,
  .reqLast, .txValid, .txReady, .txData, .txLast, .rxValid, .rxReady,
  .rxLast, .rxStatus, .rspValid, .rspReady, .rspData, .rspLast);

//--- dv/hepp_user_sink.sv
// user-side consumer of response packets
`timescale 1ns/100ps
module hepp_user_sink (
  // clock
  input wire ref_clk,
  // response handshake
  output logic rspReady
);
  initial rspReady = 1'b0;
  always @(posedge ref_clk)
    rspReady <= ($urandom % 3) != 0;
endmodule // hepp_user_sink

//--- dv/test_hepp_packet_port.sv
// self-checking bench for the header encoded packet port
`timescale 1ns/100ps
module test_hepp_packet_port;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic reqValid, reqReady, reqLast, txValid, txReady, txLast;
  logic rxValid, rxReady, rxLast, rspValid, rspReady, rspLast;
  logic [63:0] reqData, txData, rxData, rspData, h;
  logic [7:0] reqKeep, txKeep, rxKeep, rspKeep;
  logic [31:0] reqUser, txUser, rxUser, rspUser;
  logic [3:0] rxStatus;
  logic [27:0] fmts = 28'h256ABD8;
  logic [72:0] txQ[$], rspQ[$];
  int error_cnt, tests_run, i;
  hepp_packet_port u_hepp_packet_port (.ref_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reqValid,
    .reqReady, .reqData, .reqKeep, .reqLast, .reqUser, .txValid, .txReady,
    .txData, .txKeep, .txLast, .txUser, .rxValid, .rxReady, .rxData,
    .rxKeep, .rxLast, .rxUser, .rxStatus, .rspValid, .rspReady, .rspData,
    .rspKeep, .rspLast, .rspUser);
  hepp_user_sink u_hepp_user_sink (.ref_clk, .rspReady);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // link side stalls too, so held beats get exercised
  always @(posedge ref_clk)
    txReady <= ($urandom % 4) != 0;
  task automatic check(input logic [72:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task tmo;
    error_cnt++;
    conclude();
  endtask
  always @(negedge ref_clk) begin
    if (txValid && txReady)
      check({txLast, txKeep, txData}, txQ.pop_front());
    if (rspValid && rspReady)
      check({rspLast, rspKeep, rspData}, rspQ.pop_front());
  end
  task automatic apb(input logic wr, input logic [7:0] a, input [31:0] d);
    int n;
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      if (++n > 50) tmo();
    end while (!pready);
    rd = prdata;
    perr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic push(input bit rx, hd, input logic [63:0] d,
      input logic [7:0] k, input logic l, input logic [3:0] st);
    int n;
    logic [63:0] e;
    e = d;
    if (rx) begin
      {rxValid, rxData, rxKeep, rxLast, rxStatus} <= {1'b1, d, k, l, st};
      if (hd) e[35] = st != 4'h0;
      rspQ.push_back({l, k, e});
    end else begin
      {reqValid, reqData, reqKeep, reqLast} <= {1'b1, d, k, l};
      txQ.push_back({l, k, e});
    end
    n = 0;
    do begin
      @(negedge ref_clk);
      if (++n > 100) tmo();
    end while (!(rx ? rxReady : reqReady));
    @(posedge ref_clk);
  endtask
  task automatic drain;
    int n;
    for (n = 0; txQ.size() + rspQ.size() > 0; n++) begin
      @(negedge ref_clk);
      if (n > 500) tmo();
    end
  endtask
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, reqValid, reqLast, rxValid, rxLast} = '0;
    {paddr, pwdata, reqData, reqKeep, rxData, rxKeep, rxStatus} = '0;
    {reqUser, rxUser, txReady} = '0;
    void'($urandom(32'h746D));
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h7F);
    w = $urandom;
    apb(1'b1, 8'h04, w);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, w & 32'h7F);
    // unmapped place is refused
    apb(1'b0, 8'h14, 32'h0);
    check(perr, 1'b1);
    $display("test registers done");
    for (i = 0; i < 7; i++) begin
      h = {$urandom, $urandom};
      // every accepted format, subtypes 0-3 in turn
      h[55:48] = {fmts[27-4*i -: 4], 4'(i % 4)};
      // unique tag, request priority, spare bits zero
      h[63:56] = 8'(i);
      h[47:45] = {1'b0, 2'(i % 3)};
      h[35:34] = 2'b00;
      // aligned doubleword address with full size
      h[43:36] = 8'hFF;
      h[2:0] = 3'b000;
      push(1'b0, 1'b1, h, 8'hFF, i % 3 == 0, 4'h0);
      for (int s = 1; s <= i % 3; s++)
        push(1'b0, 1'b0, {$urandom, $urandom}, 8'($urandom), s == i % 3, 4'h0);
    end
    reqValid <= 1'b0;
    drain();
    apb(1'b0, 8'h08, 32'h0);
    check(rd[3:0], 4'h8);
    apb(1'b0, 8'h00, 32'h0);
    check(rd[15:0], {8'h01, 8'(7 - $countones(w[6:0]))});
    $display("test requests done");
    for (i = 0; i < 16; i++) begin
      h = {$urandom, $urandom};
      push(1'b1, 1'b1, h, 8'hFF, i[0] == 1'b0, 4'(i));
      if (i[0])
        push(1'b1, 1'b0, {$urandom, $urandom}, 8'hFF, 1'b1, 4'(i));
    end
    rxValid <= 1'b0;
    drain();
    $display("test responses done");
    conclude();
  end
endmodule // test_hepp_packet_port
